// *** core/dld_defines.vh ***
`ifndef DLD_DEFINES_VH
`define DLD_DEFINES_VH

// opcodes and opcode masks (low byte)
`define DLD_OP_NOP        8'h18
`define DLD_OP_MOV        8'hbc
`define DLD_OP_LDP        8'h25
`define DLD_MSK_LDP       8'hfd
`define DLD_OP_LP         8'h20
`define DLD_MSK_LP        8'hfd
`define DLD_OP_LPEND      8'h28
`define DLD_MSK_LPEND     8'he8

// field positions
`define DLD_BIT_X         0
`define DLD_BIT_BS        1
`define DLD_BIT_LP_LC     1
`define DLD_BIT_END_LC    2
`define DLD_BIT_NF        4
`define DLD_PERIPH_HI     15
`define DLD_PERIPH_LO     11
`define DLD_IMM8_HI       15
`define DLD_IMM8_LO       8
`define DLD_RD_HI         10
`define DLD_RD_LO         8
`define DLD_IMM32_HI      47
`define DLD_IMM32_LO      16

// move destination codes
`define DLD_RD_SAR        3'h0
`define DLD_RD_CCR        3'h1
`define DLD_RD_DAR        3'h2

// instruction lengths in bytes
`define DLD_LEN1          32'h1
`define DLD_LEN2          32'h2
`define DLD_LEN6          32'h6

// channel control fields
`define DLD_CCR_SRC_INC   0
`define DLD_CCR_SIZE_HI   3
`define DLD_CCR_SIZE_LO   1
`define DLD_CCR_BLEN_HI   7
`define DLD_CCR_BLEN_LO   4
`define DLD_SINGLE_LEN    4'h0

// peripheral acknowledge type codes
`define DLD_ACK_SINGLE    2'h0
`define DLD_ACK_BURST     2'h1

// register offsets
`define DLD_REG_CTRL      8'h00
`define DLD_REG_START_PC  8'h04
`define DLD_REG_PC        8'h08
`define DLD_REG_SRC       8'h0c
`define DLD_REG_DST       8'h10
`define DLD_REG_CCR       8'h14
`define DLD_REG_LOOP      8'h18
`define DLD_REG_STATUS    8'h1c
`define DLD_CTRL_GO       0
`define DLD_CTRL_STOP     1

// thread states
`define DLD_ST_IDLE       2'h0
`define DLD_ST_FETCH      2'h1
`define DLD_ST_RDREQ      2'h2
`define DLD_ST_RDDATA     2'h3

`endif

// *** core/dld_loop_counter.v ***
`timescale 1ns/10ps
`include "dld_defines.vh"

module dld_loop_counter #(
  parameter CNT_W = 8,
  parameter PC_W  = 32
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             load,
  input  wire [CNT_W-1:0] loadVal,
  input  wire [PC_W-1:0]  loadPc,
  input  wire             dec,
  output reg  [CNT_W-1:0] count_ff,
  output reg  [PC_W-1:0]  startPc_ff,
  output wire             isZero
);

  assign isZero = (count_ff == {CNT_W{1'b0}});

  always @(posedge clk) begin
    if (!rst_b) begin
      count_ff   <= {CNT_W{1'b0}};
      startPc_ff <= {PC_W{1'b0}};
    end else if (load) begin
      count_ff   <= loadVal;
      startPc_ff <= loadPc; // RULE9
    end else if (dec) begin
      count_ff   <= count_ff - {{(CNT_W-1){1'b0}}, 1'b1}; // RULE10
    end
  end

endmodule // dld_loop_counter

// *** core/dld_channel_decode.v ***
//Contract
//RULE1: load-notify reads at source address into fifo, then signals ack type to peripheral.
//RULE2: source address advances after load-notify when source increment is set.
//RULE3: load-notify has peripheral number bits 15:11, selector bit 1, bit 0 one.
//RULE4: selector zero: single request loads with length zero; burst request is no-op.
//RULE5: selector one: single request is no-op; burst request loads a full burst.
//RULE6: request type flag set on wait-for-peripheral; conditional loads and loop ends use it.
//RULE7: loop start bits 15:8 hold count minus one, written to chosen counter.
//RULE8: loop start counter select zero picks counter 0, one picks counter 1.
//RULE9: loop start records address of next instruction as loop body start.
//RULE10: counted loop end: zero falls through, otherwise decrement and branch back.
//RULE11: unbounded loop end branches while last flag is 0, exits when 1.
//RULE12: peripheral last-request high sets the channel last flag; here only its synchronized rising edge sets it.
//RULE13: conditional counted loop end runs only when request type matches selector.
//RULE14: loop end bits 15:8 jump back; target is loop end address minus it.
//RULE15: loop end finite flag 0 means unbounded, 1 means counted.
//RULE16: loop end counter select picks counter; unbounded loops carry one.
//RULE17: move writes 32-bit immediate: 000 source, 001 control, 010 destination.
//RULE18: no-operation only advances program counter.
//RULE19: software uses these instructions only in channel threads.
//RULE20: a conditional turned no-op only advances the program counter.
//RULE21: two independent 8-bit loop counters per channel.
`timescale 1ns/10ps
`include "dld_defines.vh"

module dld_channel_decode #(
  parameter ADDR_W = 32,
  parameter DATA_W = 32,
  parameter CNT_W  = 8
) (
  input  wire              clk,
  input  wire              rst_b,
  // register port
  input  wire [7:0]        regAddr,
  input  wire [31:0]       regWdata,
  input  wire              regWr,
  input  wire              regRd,
  output reg  [31:0]       regRdata_ff,
  // instruction fetch
  output wire              instrReq,
  output wire [ADDR_W-1:0] instrPc,
  input  wire              instrValid,
  input  wire [47:0]       instrData,
  // request type from wait-for-peripheral logic, and peripheral last request
  input  wire              wfpDone,
  input  wire              wfpBurst,
  input  wire              periphLast,
  // read channel
  output wire              rdReqValid,
  input  wire              rdReqReady,
  output wire [ADDR_W-1:0] rdReqAddr,
  output wire [3:0]        rdReqLen,
  output wire [2:0]        rdReqSize,
  input  wire              rdDataValid,
  output wire              rdDataReady,
  input  wire [DATA_W-1:0] rdData,
  input  wire              rdDataLast,
  // shared data fifo push
  output reg               fifoPushValid_ff,
  input  wire              fifoPushReady,
  output reg  [DATA_W-1:0] fifoPushData_ff,
  // peripheral acknowledge, and thread status
  output reg               ackValid_ff,
  output reg  [1:0]        ackType_ff,
  output reg  [4:0]        ackPeriph_ff,
  output wire              running,
  output wire              fault
);

  reg [1:0]        state_ff;
  reg [1:0]        nxt_state;
  reg [ADDR_W-1:0] pc_ff;
  reg [ADDR_W-1:0] nxt_pc;
  reg [ADDR_W-1:0] startPc_ff;
  reg [31:0]       sar_ff;
  reg [31:0]       nxt_sar;
  reg [31:0]       dar_ff;
  reg [31:0]       nxt_dar;
  reg [31:0]       ccr_ff;
  reg [31:0]       nxt_ccr;
  reg              running_ff;
  reg              nxt_running;
  reg              fault_ff;
  reg              nxt_fault;
  reg              reqBurst_ff;
  reg              lastFlag_ff;
  reg              ldpBurst_ff;
  reg              nxt_ldpBurst;
  reg [4:0]        ldpPeriph_ff;
  reg [4:0]        nxt_ldpPeriph;
  reg [3:0]        ldpLen_ff;
  reg [3:0]        nxt_ldpLen;
  reg [1:0]        lastSync_ff;
  reg              lastPrev_ff;
  reg [1:0]        lcLoad;
  reg [1:0]        lcDec;
  reg              ackPulse;
  reg [31:0]       stepBytes;

  wire [CNT_W-1:0]  lcCount0;
  wire [CNT_W-1:0]  lcCount1;
  wire [ADDR_W-1:0] lcStart0;
  wire [ADDR_W-1:0] lcStart1;
  wire              lcZero0;
  wire              lcZero1;

  wire [7:0]  op       = instrData[7:0];
  wire [7:0]  imm8     = instrData[`DLD_IMM8_HI:`DLD_IMM8_LO];
  wire [2:0]  movRd    = instrData[`DLD_RD_HI:`DLD_RD_LO];
  wire [31:0] imm32    = instrData[`DLD_IMM32_HI:`DLD_IMM32_LO];
  wire        opBs     = op[`DLD_BIT_BS];
  wire        endLc    = op[`DLD_BIT_END_LC];
  wire        endCond  = op[`DLD_BIT_X];
  wire        endNf    = op[`DLD_BIT_NF];
  wire        goCmd    = regWr && (regAddr == `DLD_REG_CTRL) && regWdata[`DLD_CTRL_GO];
  wire        stopCmd  = regWr && (regAddr == `DLD_REG_CTRL) && regWdata[`DLD_CTRL_STOP];
  wire        lastRise = lastSync_ff[1] && !lastPrev_ff;
  wire        beatTake = rdDataValid && rdDataReady;

  // loop end target is loop end address minus the backward jump
  wire [ADDR_W-1:0] jumpBack = pc_ff - {{(ADDR_W-8){1'b0}}, imm8}; // RULE14

  assign instrReq    = running_ff && (state_ff == `DLD_ST_FETCH);
  assign instrPc     = pc_ff;
  assign rdReqValid  = (state_ff == `DLD_ST_RDREQ);
  assign rdReqAddr   = sar_ff[ADDR_W-1:0];
  assign rdReqLen    = ldpLen_ff;
  assign rdReqSize   = ccr_ff[`DLD_CCR_SIZE_HI:`DLD_CCR_SIZE_LO];
  // one holding stage toward the fifo; a full fifo stalls the read data
  assign rdDataReady = (state_ff == `DLD_ST_RDDATA) && (!fifoPushValid_ff || fifoPushReady);
  assign running     = running_ff;
  assign fault       = fault_ff;

  dld_loop_counter #(
    .CNT_W (CNT_W),
    .PC_W  (ADDR_W)
  ) u_loop0 (
    .clk        (clk),
    .rst_b      (rst_b),
    .load       (lcLoad[0]),
    .loadVal    (imm8[CNT_W-1:0]),
    .loadPc     (nxt_pc),
    .dec        (lcDec[0]),
    .count_ff   (lcCount0),
    .startPc_ff (lcStart0),
    .isZero     (lcZero0)
  ); // RULE21

  dld_loop_counter #(
    .CNT_W (CNT_W),
    .PC_W  (ADDR_W)
  ) u_loop1 (
    .clk        (clk),
    .rst_b      (rst_b),
    .load       (lcLoad[1]),
    .loadVal    (imm8[CNT_W-1:0]),
    .loadPc     (nxt_pc),
    .dec        (lcDec[1]),
    .count_ff   (lcCount1),
    .startPc_ff (lcStart1),
    .isZero     (lcZero1)
  ); // RULE21

  always @* begin
    nxt_state     = state_ff;
    nxt_pc        = pc_ff;
    nxt_sar       = sar_ff;
    nxt_dar       = dar_ff;
    nxt_ccr       = ccr_ff;
    nxt_running   = running_ff;
    nxt_fault     = fault_ff;
    nxt_ldpBurst  = ldpBurst_ff;
    nxt_ldpPeriph = ldpPeriph_ff;
    nxt_ldpLen    = ldpLen_ff;
    lcLoad        = 2'b00;
    lcDec         = 2'b00;
    ackPulse      = 1'b0;
    stepBytes     = (({28'h0, ldpLen_ff}) + 32'h1)
                    << ccr_ff[`DLD_CCR_SIZE_HI:`DLD_CCR_SIZE_LO];
    case (state_ff)
      `DLD_ST_IDLE: begin
        if (goCmd) begin
          nxt_pc      = startPc_ff;
          nxt_running = 1'b1;
          nxt_fault   = 1'b0;
          nxt_state   = `DLD_ST_FETCH;
        end
      end
      `DLD_ST_FETCH: begin
        if (stopCmd) begin
          nxt_running = 1'b0;
          nxt_state   = `DLD_ST_IDLE;
        end else if (instrValid) begin
          if (op == `DLD_OP_NOP) begin
            nxt_pc = pc_ff + `DLD_LEN1; // RULE18
          end else if ((op & `DLD_MSK_LDP) == `DLD_OP_LDP) begin // RULE3
            nxt_ldpBurst  = opBs;
            nxt_ldpPeriph = instrData[`DLD_PERIPH_HI:`DLD_PERIPH_LO]; // RULE3
            // single ignores the configured burst length
            nxt_ldpLen    = opBs ? ccr_ff[`DLD_CCR_BLEN_HI:`DLD_CCR_BLEN_LO]
                                 : `DLD_SINGLE_LEN; // RULE4 RULE5
            if (opBs == reqBurst_ff) begin // RULE4 RULE5 RULE6
              nxt_state = `DLD_ST_RDREQ;
            end else begin
              nxt_pc = pc_ff + `DLD_LEN2; // RULE20
            end
          end else if ((op & `DLD_MSK_LP) == `DLD_OP_LP) begin
            nxt_pc = pc_ff + `DLD_LEN2; // RULE9
            lcLoad = op[`DLD_BIT_LP_LC] ? 2'b10 : 2'b01; // RULE7 RULE8
          end else if ((op & `DLD_MSK_LPEND) == `DLD_OP_LPEND) begin
            nxt_pc = pc_ff + `DLD_LEN2; // RULE20
            if (!endNf) begin // RULE15 RULE16
              if (!lastFlag_ff) begin
                nxt_pc = jumpBack; // RULE11
              end
            end else if (!endCond || (opBs == reqBurst_ff)) begin // RULE13 RULE6
              if (endLc ? !lcZero1 : !lcZero0) begin // RULE10 RULE16
                nxt_pc = jumpBack; // RULE10 RULE14
                lcDec  = endLc ? 2'b10 : 2'b01;
              end
            end
          end else if (op == `DLD_OP_MOV) begin
            nxt_pc = pc_ff + `DLD_LEN6;
            case (movRd) // RULE17
              `DLD_RD_SAR: nxt_sar = imm32;
              `DLD_RD_CCR: nxt_ccr = imm32;
              `DLD_RD_DAR: nxt_dar = imm32;
              default: begin
                nxt_fault   = 1'b1;
                nxt_running = 1'b0;
                nxt_state   = `DLD_ST_IDLE;
              end
            endcase
          end else begin
            // opcodes owned by other blocks are not ours to run
            nxt_fault   = 1'b1;
            nxt_running = 1'b0;
            nxt_state   = `DLD_ST_IDLE;
          end
        end
      end
      `DLD_ST_RDREQ: begin
        if (rdReqReady) begin
          nxt_state = `DLD_ST_RDDATA; // RULE1
        end
      end
      `DLD_ST_RDDATA: begin
        if (beatTake && rdDataLast) begin
          ackPulse  = 1'b1; // RULE1
          nxt_pc    = pc_ff + `DLD_LEN2;
          nxt_state = `DLD_ST_FETCH;
          if (ccr_ff[`DLD_CCR_SRC_INC]) begin
            nxt_sar = sar_ff + stepBytes; // RULE2
          end
        end
      end
      default: begin
        nxt_state = `DLD_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state_ff     <= `DLD_ST_IDLE;
      pc_ff        <= {ADDR_W{1'b0}};
      sar_ff       <= 32'h0;
      dar_ff       <= 32'h0;
      ccr_ff       <= 32'h0;
      running_ff   <= 1'b0;
      fault_ff     <= 1'b0;
      ldpBurst_ff  <= 1'b0;
      ldpPeriph_ff <= 5'h0;
      ldpLen_ff    <= 4'h0;
      ackValid_ff  <= 1'b0;
      ackType_ff   <= 2'h0;
      ackPeriph_ff <= 5'h0;
    end else begin
      state_ff     <= nxt_state;
      pc_ff        <= nxt_pc;
      sar_ff       <= nxt_sar;
      dar_ff       <= nxt_dar;
      ccr_ff       <= nxt_ccr;
      running_ff   <= nxt_running;
      fault_ff     <= nxt_fault;
      ldpBurst_ff  <= nxt_ldpBurst;
      ldpPeriph_ff <= nxt_ldpPeriph;
      ldpLen_ff    <= nxt_ldpLen;
      ackValid_ff  <= ackPulse; // RULE1
      if (ackPulse) begin
        ackType_ff   <= ldpBurst_ff ? `DLD_ACK_BURST : `DLD_ACK_SINGLE;
        ackPeriph_ff <= ldpPeriph_ff;
      end
    end
  end

  // data holding stage into the shared fifo
  always @(posedge clk) begin
    if (!rst_b) begin
      fifoPushValid_ff <= 1'b0;
      fifoPushData_ff  <= {DATA_W{1'b0}};
    end else if (beatTake) begin
      fifoPushValid_ff <= 1'b1; // RULE1
      fifoPushData_ff  <= rdData;
    end else if (fifoPushReady) begin
      fifoPushValid_ff <= 1'b0;
    end
  end

  // request flags and start pc register; a set in the clearing cycle wins
  always @(posedge clk) begin
    if (!rst_b) begin
      lastSync_ff <= 2'b00;
      lastPrev_ff <= 1'b0;
      reqBurst_ff <= 1'b0;
      lastFlag_ff <= 1'b0;
      startPc_ff  <= {ADDR_W{1'b0}};
    end else begin
      lastSync_ff <= {lastSync_ff[0], periphLast};
      lastPrev_ff <= lastSync_ff[1];
      if (wfpDone) begin
        reqBurst_ff <= wfpBurst; // RULE6
      end
      if (lastRise) begin
        lastFlag_ff <= 1'b1; // RULE12
      end else if (goCmd && (state_ff == `DLD_ST_IDLE)) begin
        lastFlag_ff <= 1'b0;
      end
      if (regWr && (regAddr == `DLD_REG_START_PC)) begin
        startPc_ff <= regWdata[ADDR_W-1:0];
      end
    end
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      regRdata_ff <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        `DLD_REG_CTRL:     regRdata_ff <= 32'h0;
        `DLD_REG_START_PC: regRdata_ff <= startPc_ff;
        `DLD_REG_PC:       regRdata_ff <= pc_ff;
        `DLD_REG_SRC:      regRdata_ff <= sar_ff;
        `DLD_REG_DST:      regRdata_ff <= dar_ff;
        `DLD_REG_CCR:      regRdata_ff <= ccr_ff;
        `DLD_REG_LOOP:     regRdata_ff <= {16'h0, lcCount1, lcCount0};
        `DLD_REG_STATUS:   regRdata_ff <= {26'h0, state_ff, lastFlag_ff, reqBurst_ff,
                                           fault_ff, running_ff};
        default:           regRdata_ff <= 32'h0;
      endcase
    end else begin
      regRdata_ff <= 32'h0;
    end
  end

endmodule // dld_channel_decode

// *** verification/dld_channel_decode_checker.sv ***
`timescale 1ns/10ps
module dld_channel_decode_checker (
  input wire        clk,
  input wire        rst_b,
  input wire        regWr,
  input wire        instrReq,
  input wire [31:0] instrPc,
  input wire        instrValid,
  input wire [47:0] instrData,
  input wire        wfpDone,
  input wire        wfpBurst,
  input wire        rdReqValid,
  input wire        rdReqReady,
  input wire [31:0] rdReqAddr,
  input wire [3:0]  rdReqLen,
  input wire        rdDataValid,
  input wire        rdDataReady,
  input wire        rdDataLast,
  input wire        ackValid_ff,
  input wire [1:0]  ackType_ff,
  input wire [4:0]  ackPeriph_ff
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  reg        typ_ff;
  reg  [4:0] per_ff;
  wire       take = instrReq && instrValid && !regWr;
  wire [7:0] op   = instrData[7:0];
  wire       ldp  = take && ((op & 8'hfd) == 8'h25);
  // mirror of the request type, since the flag itself is internal
  always @(posedge clk) begin
    if (!rst_b) begin
      typ_ff <= 1'b0;
      per_ff <= 5'h0;
    end else begin
      if (wfpDone)
        typ_ff <= wfpBurst;
      if (ldp)
        per_ff <= instrData[15:11];
    end
  end
  a_ack_after_last: assert property (
    rdDataValid && rdDataReady && rdDataLast |=> ackValid_ff)
    else $error("no ack after last read beat");
  a_ack_one_cycle: assert property (ackValid_ff |=> !ackValid_ff)
    else $error("ack longer than one cycle");
  a_ack_type: assert property (ackValid_ff |-> ackType_ff == {1'b0, typ_ff})
    else $error("ack type differs from request type");
  a_ack_periph: assert property (ackValid_ff |-> ackPeriph_ff == per_ff)
    else $error("ack peripheral number wrong");
  a_load_starts: assert property (ldp && op[1] == typ_ff |=> rdReqValid)
    else $error("matching load issued no read");
  a_cond_skip: assert property (ldp && op[1] != typ_ff |=>
    !rdReqValid && instrPc == $past(instrPc) + 32'h2)
    else $error("skipped load not a plain step");
  a_single_len: assert property (rdReqValid && !typ_ff |-> rdReqLen == 4'h0)
    else $error("single load length not zero");
  a_req_holds: assert property (rdReqValid && !rdReqReady |=>
    rdReqValid && $stable(rdReqAddr))
    else $error("read request dropped or changed");
  a_load_ends: assert property (rdReqValid && rdReqReady |-> ##[1:60] ackValid_ff)
    else $error("load never acknowledged");
  a_nop_step: assert property (take && op == 8'h18 |=> instrPc == $past(instrPc) + 32'h1)
    else $error("nop step wrong");
  a_mov_step: assert property (take && op == 8'hbc |=> instrPc == $past(instrPc) + 32'h6)
    else $error("move step wrong");
  a_lp_step: assert property (take && (op & 8'hfd) == 8'h20 |=>
    instrPc == $past(instrPc) + 32'h2)
    else $error("loop start step wrong");
  c_burst_ack: cover property (ackValid_ff && ackType_ff == 2'h1);
  c_skip: cover property (ldp && op[1] != typ_ff);
  c_stall: cover property (rdReqValid && !rdReqReady);
endmodule // dld_channel_decode_checker

bind dld_channel_decode dld_channel_decode_checker dld_channel_decode_checker_inst (.*);

// *** verification/dld_mem_model.sv ***
`timescale 1ns/10ps
module dld_mem_model (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        slow,
  input  wire        instrReq,
  input  wire [31:0] instrPc,
  output wire        instrValid,
  output wire [47:0] instrData,
  input  wire        rdReqValid,
  output wire        rdReqReady,
  input  wire [31:0] rdReqAddr,
  input  wire [3:0]  rdReqLen,
  output wire        rdDataValid,
  input  wire        rdDataReady,
  output wire [31:0] rdData,
  output wire        rdDataLast,
  output wire        fifoPushReady
);
  reg  [7:0]  prog [0:255];
  reg  [4:0]  left_ff;
  reg  [31:0] addr_ff;
  reg         stall_ff;
  wire [7:0]  p = instrPc[7:0];
  integer     i;
  initial begin
    for (i = 0; i < 256; i = i + 1)
      prog[i] = 8'hff;
  end
  assign instrValid = instrReq;
  assign instrData = {prog[p+8'h5], prog[p+8'h4], prog[p+8'h3],
                      prog[p+8'h2], prog[p+8'h1], prog[p]};
  // one read outstanding; slow mode stalls every other cycle
  assign rdReqReady    = rdReqValid && left_ff == 5'h0 && !stall_ff;
  assign rdDataValid   = left_ff != 5'h0 && !stall_ff;
  // idle beats show inverted values so stale data cannot pass
  assign rdData        = rdDataValid ? addr_ff : ~addr_ff;
  assign rdDataLast    = (left_ff == 5'h1) ~^ rdDataValid;
  assign fifoPushReady = !stall_ff;
  always @(posedge clk) begin
    if (!rst_b) begin
      left_ff  <= 5'h0;
      addr_ff  <= 32'h0;
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= slow & !stall_ff;
      if (rdReqValid && rdReqReady) begin
        left_ff <= {1'b0, rdReqLen} + 5'h1;
        addr_ff <= rdReqAddr;
      end else if (rdDataValid && rdDataReady) begin
        left_ff <= left_ff - 5'h1;
        addr_ff <= addr_ff + 32'h4;
      end
    end
  end
endmodule // dld_mem_model

// *** verification/test_dld_channel_decode.sv ***
`timescale 1ns/10ps
module test_dld_channel_decode;
  typedef struct packed {
    logic [47:0] i;
    logic        t;
    logic [31:0] d;
    logic [7:0]  a;
    logic [31:0] e;
  } dld_row_t;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg  [7:0]  regAddr = 8'h0;
  reg  [31:0] regWdata = 32'h0;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  reg         wfpDone = 1'b0;
  reg         wfpBurst = 1'b0;
  reg         periphLast = 1'b0;
  reg         slow = 1'b0;
  wire [31:0] regRdata_ff, instrPc, rdReqAddr, rdData, fifoPushData_ff;
  wire [47:0] instrData;
  wire [3:0]  rdReqLen;
  wire [2:0]  rdReqSize;
  wire [1:0]  ackType_ff;
  wire [4:0]  ackPeriph_ff;
  wire        instrReq, instrValid, rdReqValid, rdReqReady, rdDataValid, rdDataReady;
  wire        rdDataLast, fifoPushValid_ff, fifoPushReady, ackValid_ff, running, fault;
  integer     errors = 0;
  integer     n_checks = 0;
  integer     pushes = 0;
  integer     k;
  reg  [31:0] got;
  reg  [31:0] pcs [$];
  // channel-thread programs only
  dld_row_t   rows [0:15] = '{
    '{48'h1000000000bc, 1'b0, 32'h6, 8'h0c, 32'h10000000},
    '{48'h0000003501bc, 1'b0, 32'h6, 8'h14, 32'h35},
    '{48'h2000000002bc, 1'b0, 32'h6, 8'h10, 32'h20000000},
    '{48'h0520, 1'b0, 32'h2, 8'h18, 32'h0005},
    '{48'hff22, 1'b0, 32'h2, 8'h18, 32'hff05},
    '{48'h1825, 1'b0, 32'h2, 8'h0c, 32'h10000004},
    '{48'h2827, 1'b0, 32'h2, 8'h0c, 32'h10000004},
    '{48'h1825, 1'b1, 32'h2, 8'h0c, 32'h10000004},
    '{48'hf827, 1'b1, 32'h2, 8'h0c, 32'h10000014},
    '{48'h0018, 1'b1, 32'h1, 8'h14, 32'h35},
    '{48'h0438, 1'b1, 32'hfffffffc, 8'h18, 32'hff04},
    '{48'h043b, 1'b0, 32'h2, 8'h18, 32'hff04},
    '{48'h083d, 1'b0, 32'hfffffff8, 8'h18, 32'hfe04},
    '{48'h0020, 1'b0, 32'h2, 8'h18, 32'hfe00},
    '{48'h0438, 1'b0, 32'h2, 8'h18, 32'hfe00},
    '{48'h062c, 1'b0, 32'hfffffffa, 8'h18, 32'hfe00}
  };
  dld_channel_decode dld_channel_decode_inst (.*);
  dld_mem_model dld_mem_model_inst (.*);
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (instrReq && instrValid)
      pcs.push_back(instrPc);
    if (rdReqValid && rdReqReady)
      check("read size", 32'h2, rdReqSize);
    // the model returns the address as data, and every load here continues the last
    if (fifoPushValid_ff && fifoPushReady) begin
      check("fifo data", 32'h10000000 + 32'h4 * pushes, fifoPushData_ff);
      pushes = pushes + 1;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task check(input string what, input [31:0] exp, input [31:0] seen);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("BAD %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
      @(posedge clk);
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [7:0] a, output [31:0] d);
    begin
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdata_ff;
      @(posedge clk);
    end
  endtask
  task wfp(input t);
    begin
      wfpBurst <= t;
      wfpDone <= 1'b1;
      @(posedge clk);
      wfpDone <= 1'b0;
    end
  endtask
  // every program ends on an unknown opcode, so the thread stops itself
  task go_and_wait;
    integer n;
    begin
      pcs = {};
      wr(8'h04, 32'h40);
      wr(8'h00, 32'h1);
      for (n = 0; n < 400 && (pcs.size() < 2 || running); n = n + 1)
        @(posedge clk);
      if (n == 400) begin
        errors = errors + 1;
        report_and_stop;
      end
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    check("idle outputs", 32'h0, {running, instrReq, rdReqValid, ackValid_ff, fault});
    rd(8'h20, got);
    check("unmapped read", 32'h0, got);
    for (k = 0; k < 16; k = k + 1) begin
      for (int b = 0; b < 6; b++)
        dld_mem_model_inst.prog[8'h40+b] = rows[k].i[8*b +: 8];
      wfp(rows[k].t);
      go_and_wait;
      check("pc step", rows[k].d, pcs[1] - pcs[0]);
      rd(rows[k].a, got);
      check("register", rows[k].e, got);
    end
    check("fifo pushes", 32'h5, pushes);
    for (int b = 0; b < 8; b++)
      dld_mem_model_inst.prog[8'h40+b] = 8'h18;
    dld_mem_model_inst.prog[8'h48] = 8'h2c;
    dld_mem_model_inst.prog[8'h49] = 8'h08;
    dld_mem_model_inst.prog[8'h4a] = 8'hff;
    periphLast <= 1'b1;
    go_and_wait;
    check("unbounded exit", 32'h4a, pcs[pcs.size()-1]);
    periphLast <= 1'b0;
    slow <= 1'b1;
    dld_mem_model_inst.prog[8'h40] = 8'h27;
    dld_mem_model_inst.prog[8'h41] = 8'hf8;
    dld_mem_model_inst.prog[8'h42] = 8'h00;
    wfp(1'b1);
    go_and_wait;
    rd(8'h0c, got);
    check("stalled burst source", 32'h10000024, got);
    check("stalled burst pushes", 32'h9, pushes);
    // unbounded loop end on itself with the last flag clear spins until stopped
    dld_mem_model_inst.prog[8'h40] = 8'h2c;
    dld_mem_model_inst.prog[8'h41] = 8'h00;
    wr(8'h00, 32'h1);
    check("loop spin", 32'h1, running);
    wr(8'h00, 32'h2);
    check("stopped", 32'h0, {running, fault});
    dld_mem_model_inst.prog[8'h40] = 8'hbc;
    dld_mem_model_inst.prog[8'h41] = 8'h03;
    wr(8'h00, 32'h1);
    @(posedge clk);
    check("bad move", 32'h1, {running, fault});
    report_and_stop;
  end
endmodule // test_dld_channel_decode
